// ==== serial_host_flow_bridge_pkg.sv ====
`default_nettype none
package serial_host_flow_bridge_pkg;
    localparam int          CLK_HZ       = 200_000_000;
    localparam int          DEFAULT_BAUD = 57600;
    localparam int          OVERSAMPLE   = 16;
    localparam logic [15:0] DEFAULT_DIV  = 16'(CLK_HZ / (DEFAULT_BAUD * OVERSAMPLE));
    localparam int          FIFO_WIDTH   = 8;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          LEVEL_W      = 5;
    localparam logic [4:0]  FIFO_FULL    = 5'h10;
    localparam logic [4:0]  CTS_MARGIN   = 5'h04;
    localparam logic [3:0]  MID_TICK     = 4'h7;
    localparam logic [3:0]  LAST_TICK    = 4'hF;
    localparam logic [2:0]  LAST_BIT     = 3'h7;
    localparam logic        CTS_N_RESET  = 1'b0;

    typedef enum logic [4:0] {
        RX_IDLE  = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA  = 5'b00100,
        RX_PAR   = 5'b01000,
        RX_STOP  = 5'b10000
    } rx_state_e;

    typedef enum logic [4:0] {
        TX_IDLE  = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA  = 5'b00100,
        TX_PAR   = 5'b01000,
        TX_STOP  = 5'b10000
    } tx_state_e;
endpackage
`default_nettype wire

// ==== char_fifo.sv ====
`default_nettype none
module char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                       clk_sys,
    input  wire logic                       nrst,
    input  wire logic [WIDTH-1:0]           in_data,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    output logic [WIDTH-1:0]                out_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;
    logic [AW-1:0]    rd_next;
    logic [LW-1:0]    cnt_reg;
    logic [LW-1:0]    cnt_next;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg != LW'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
    assign level     = cnt_reg;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
        rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = LW'(cnt_reg + 1'b1);
        end else if (pop && !push) begin
            cnt_next = LW'(cnt_reg - 1'b1);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ==== serial_host_flow_bridge.sv ====
// Behaviour
// [RL1] forward every bus frame, no address filter
// [RL2] radio packet goes onto bus at once
// [RL3] bus nodes never drive simultaneously
// [RL4] handshake option uses separate flow lines
// [RL5] assert clear-to-send while able to accept
// [RL6] send to host only while RTS low
// [RL7] hold host transmission while RTS high
// [RL8] clear-to-send active regardless of handshake option
// [RL9] no handshake lines in RS-485 mode; host_cts_n still resets to CTS_N_RESET, low (active), in either mode
// [RL10] flow control stays local, not over radio
// [RL11] host rate configurable, default 57600 bps
// [RL12] parity gives 8 data plus parity bit
// [RL13] drop clear-to-send before buffer overflows
`default_nettype none
module serial_host_flow_bridge
    import serial_host_flow_bridge_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        rs485_mode,
    input  wire logic        rts_enable,
    input  wire logic        parity_enable,
    input  wire logic        parity_odd,
    input  wire logic [15:0] baud_div,
    input  wire logic        host_rxd,
    output logic             host_txd,
    input  wire logic        host_rts_n,
    output logic             host_cts_n,
    input  wire logic        bus_rxd,
    output logic             bus_txd,
    output logic             bus_de,
    output logic [7:0]       radio_out_data,
    output logic             radio_out_valid,
    input  wire logic        radio_out_ready,
    input  wire logic [7:0]  radio_in_data,
    input  wire logic        radio_in_valid,
    output logic             radio_in_ready,
    output logic             parity_err,
    output logic             frame_err,
    output logic             overrun_err
);
    logic [15:0]        div_reg;
    logic [15:0]        div_next;
    logic [15:0]        div_eff;
    logic               tick;
    rx_state_e          rx_state_reg;
    rx_state_e          rx_state_next;
    logic [3:0]         rx_os_reg;
    logic [3:0]         rx_os_next;
    logic [2:0]         rx_bit_reg;
    logic [2:0]         rx_bit_next;
    logic [7:0]         rx_shift_reg;
    logic [7:0]         rx_shift_next;
    logic               rx_par_reg;
    logic               rx_par_next;
    logic               rx_bad_reg;
    logic               rx_bad_next;
    logic               rx_line;
    logic               rx_push;
    logic               perr_next;
    logic               ferr_next;
    logic               oerr_next;
    logic               perr_reg;
    logic               ferr_reg;
    logic               oerr_reg;
    tx_state_e          tx_state_reg;
    tx_state_e          tx_state_next;
    logic [3:0]         tx_os_reg;
    logic [3:0]         tx_os_next;
    logic [2:0]         tx_bit_reg;
    logic [2:0]         tx_bit_next;
    logic [7:0]         tx_shift_reg;
    logic [7:0]         tx_shift_next;
    logic               tx_par_reg;
    logic               tx_par_next;
    logic               line_reg;
    logic               line_next;
    logic               de_reg;
    logic               de_next;
    logic               cts_n_reg;
    logic               cts_n_next;
    logic               tx_allowed;
    logic               tx_accept;
    logic               fifo_in_ready;
    logic [LEVEL_W-1:0] fifo_level;

    // oversample tick at 16x the host rate
    assign div_eff = (baud_div == 16'h0000) ? DEFAULT_DIV : baud_div; // see [RL11]
    assign tick    = (div_reg == 16'(div_eff - 16'h0001));

    always_comb begin
        div_next = tick ? 16'h0000 : 16'(div_reg + 16'h0001);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_next;
        end
    end

    // receive from host or bus; own echo ignored while driving the bus
    assign rx_line = rs485_mode ? bus_rxd : host_rxd;

    always_comb begin
        rx_state_next = rx_state_reg;
        rx_os_next    = rx_os_reg;
        rx_bit_next   = rx_bit_reg;
        rx_shift_next = rx_shift_reg;
        rx_par_next   = rx_par_reg;
        rx_bad_next   = rx_bad_reg;
        rx_push       = 1'b0;
        perr_next     = 1'b0;
        ferr_next     = 1'b0;
        if (tick) begin
            case (rx_state_reg)
                RX_IDLE: begin
                    if (!rx_line && !de_reg) begin
                        rx_state_next = RX_START;
                        rx_os_next    = 4'h0;
                    end
                end
                RX_START: begin
                    if (rx_os_reg == MID_TICK) begin
                        rx_state_next = rx_line ? RX_IDLE : RX_DATA;
                        rx_os_next    = 4'h0;
                        rx_bit_next   = 3'h0;
                        rx_par_next   = 1'b0;
                        rx_bad_next   = 1'b0;
                    end else begin
                        rx_os_next = 4'(rx_os_reg + 4'h1);
                    end
                end
                RX_DATA: begin
                    if (rx_os_reg == LAST_TICK) begin
                        rx_os_next    = 4'h0;
                        rx_shift_next = {rx_line, rx_shift_reg[7:1]};
                        rx_par_next   = rx_par_reg ^ rx_line;
                        if (rx_bit_reg == LAST_BIT) begin
                            rx_state_next = parity_enable ? RX_PAR : RX_STOP; // see [RL12]
                        end else begin
                            rx_bit_next = 3'(rx_bit_reg + 3'h1);
                        end
                    end else begin
                        rx_os_next = 4'(rx_os_reg + 4'h1);
                    end
                end
                RX_PAR: begin
                    if (rx_os_reg == LAST_TICK) begin
                        rx_os_next    = 4'h0;
                        rx_bad_next   = (rx_par_reg ^ rx_line) != parity_odd; // see [RL12]
                        rx_state_next = RX_STOP;
                    end else begin
                        rx_os_next = 4'(rx_os_reg + 4'h1);
                    end
                end
                RX_STOP: begin
                    if (rx_os_reg == LAST_TICK) begin
                        rx_state_next = RX_IDLE;
                        rx_os_next    = 4'h0;
                        if (!rx_line) begin
                            ferr_next = 1'b1;
                        end else if (rx_bad_reg) begin
                            perr_next = 1'b1;
                        end else begin
                            rx_push = 1'b1; // see [RL1]
                        end
                    end else begin
                        rx_os_next = 4'(rx_os_reg + 4'h1);
                    end
                end
                default: begin
                    rx_state_next = RX_IDLE;
                end
            endcase
        end
        oerr_next = rx_push && !fifo_in_ready;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rx_state_reg <= RX_IDLE;
            rx_os_reg    <= 4'h0;
            rx_bit_reg   <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_par_reg   <= 1'b0;
            rx_bad_reg   <= 1'b0;
            perr_reg     <= 1'b0;
            ferr_reg     <= 1'b0;
            oerr_reg     <= 1'b0;
        end else begin
            rx_state_reg <= rx_state_next;
            rx_os_reg    <= rx_os_next;
            rx_bit_reg   <= rx_bit_next;
            rx_shift_reg <= rx_shift_next;
            rx_par_reg   <= rx_par_next;
            rx_bad_reg   <= rx_bad_next;
            perr_reg     <= perr_next;
            ferr_reg     <= ferr_next;
            oerr_reg     <= oerr_next;
        end
    end

    char_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_data   (rx_shift_reg),
        .in_valid  (rx_push),
        .in_ready  (fifo_in_ready),
        .out_data  (radio_out_data),
        .out_valid (radio_out_valid),
        .out_ready (radio_out_ready),
        .level     (fifo_level)
    );

    // transmit side: handshake gating only on the RS-232 port
    assign tx_allowed     = rs485_mode || !rts_enable || !host_rts_n; // see [RL4] see [RL6] see [RL7] see [RL9]
    assign radio_in_ready = (tx_state_reg == TX_IDLE) && tx_allowed;
    assign tx_accept      = radio_in_valid && radio_in_ready;

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_os_next    = tx_os_reg;
        tx_bit_next   = tx_bit_reg;
        tx_shift_next = tx_shift_reg;
        tx_par_next   = tx_par_reg;
        line_next     = line_reg;
        if (tx_state_reg == TX_IDLE) begin
            line_next = 1'b1;
            if (tx_accept) begin
                tx_state_next = TX_START; // see [RL2]
                tx_os_next    = 4'h0;
                tx_shift_next = radio_in_data;
                tx_par_next   = (^radio_in_data) ^ parity_odd;
                line_next     = 1'b0;
            end
        end else if (tick) begin
            if (tx_os_reg != LAST_TICK) begin
                tx_os_next = 4'(tx_os_reg + 4'h1);
            end else begin
                tx_os_next = 4'h0;
                case (tx_state_reg)
                    TX_START: begin
                        tx_state_next = TX_DATA;
                        tx_bit_next   = 3'h0;
                        line_next     = tx_shift_reg[0];
                    end
                    TX_DATA: begin
                        tx_shift_next = {1'b1, tx_shift_reg[7:1]};
                        if (tx_bit_reg == LAST_BIT) begin
                            tx_state_next = parity_enable ? TX_PAR : TX_STOP; // see [RL12]
                            line_next     = parity_enable ? tx_par_reg : 1'b1;
                        end else begin
                            tx_bit_next = 3'(tx_bit_reg + 3'h1);
                            line_next   = tx_shift_reg[1];
                        end
                    end
                    TX_PAR: begin
                        tx_state_next = TX_STOP;
                        line_next     = 1'b1;
                    end
                    default: begin
                        tx_state_next = TX_IDLE;
                        line_next     = 1'b1;
                    end
                endcase
            end
        end
        // driver enabled only for our own frame, bus idle otherwise
        de_next    = rs485_mode && (tx_state_next != TX_IDLE); // see [RL3]
        // clear-to-send from local buffer room only in RS-232 mode; held high in RS-485 mode
        cts_n_next = rs485_mode || ((FIFO_FULL - fifo_level) < CTS_MARGIN); // see [RL5] see [RL8] see [RL9] see [RL13]
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tx_state_reg <= TX_IDLE;
            tx_os_reg    <= 4'h0;
            tx_bit_reg   <= 3'h0;
            tx_shift_reg <= 8'h00;
            tx_par_reg   <= 1'b0;
            line_reg     <= 1'b1;
            de_reg       <= 1'b0;
            cts_n_reg    <= CTS_N_RESET;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_os_reg    <= tx_os_next;
            tx_bit_reg   <= tx_bit_next;
            tx_shift_reg <= tx_shift_next;
            tx_par_reg   <= tx_par_next;
            line_reg     <= line_next;
            de_reg       <= de_next;
            cts_n_reg    <= cts_n_next;
        end
    end

    assign host_txd    = rs485_mode ? 1'b1 : line_reg;
    assign bus_txd     = line_reg;
    assign bus_de      = de_reg;
    assign host_cts_n  = cts_n_reg;
    assign parity_err  = perr_reg;
    assign frame_err   = ferr_reg;
    assign overrun_err = oerr_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_bus_accept;
        tx_accept && rs485_mode;
    endsequence
    sequence s_bus_start;
        bus_de && !bus_txd && (tx_state_reg == TX_START);
    endsequence

    AST_CTS_FULL:  assert property (!rs485_mode && (fifo_level > 5'h0C) |=> host_cts_n) // see [RL13]
        else $error("cts still asserted with buffer nearly full");
    AST_CTS_ROOM:  assert property (!rs485_mode && (fifo_level <= 5'h0C) |=> !host_cts_n) // see [RL5]
        else $error("cts withheld although buffer has room");
    AST_CTS_DEF:   assert property (!rs485_mode && !rts_enable && (fifo_level == 5'h00) |=> !host_cts_n) // see [RL8]
        else $error("cts not active without handshake option");
    AST_RTS_HOLD:  assert property (rts_enable && !rs485_mode && host_rts_n |-> !radio_in_ready) // see [RL7]
        else $error("character accepted for host while rts high");
    AST_RTS_SEND:  assert property (rts_enable && !rs485_mode && !host_rts_n // see [RL6]
                                    && (tx_state_reg == TX_IDLE) |-> radio_in_ready)
        else $error("idle transmitter refuses while rts low");
    AST_NO_HS:     assert property (rs485_mode |=> host_cts_n) // see [RL9]
        else $error("handshake line active in bus mode");
    AST_BUS_NOW:   assert property (s_bus_accept |=> s_bus_start ##1 bus_de [*8]) // see [RL2]
        else $error("radio packet not driven onto bus at once");
    AST_FORWARD:   assert property (rx_push && fifo_in_ready // see [RL1]
                                    && !(radio_out_valid && radio_out_ready)
                                    |=> fifo_level == 5'($past(fifo_level) + 5'h01))
        else $error("received bus frame not forwarded");
    AST_LOCAL:     assert property (rx_push && fifo_in_ready |=> radio_out_valid) // see [RL10]
        else $error("radio forwarding throttled by host handshake");
    AST_PAR_FRAME: assert property ((tx_state_reg == TX_DATA) && tick && (tx_os_reg == LAST_TICK) // see [RL12]
                                    && (tx_bit_reg == LAST_BIT) && parity_enable |=> tx_state_reg == TX_PAR)
        else $error("parity bit missing after eight data bits");
endmodule
`default_nettype wire

// ==== serial_peer_model.sv ====
`default_nettype none
module serial_peer_model
    import serial_host_flow_bridge_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic [15:0] baud_div,
    input  wire logic        line_in,
    input  wire logic        bus_de,
    output logic             line_out,
    output logic             rts_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] rx_byte;
    logic [7:0] rx_q[$];
    logic       rx_ninth;
    int         bit_cyc;

    assign bit_cyc = 16 * ((baud_div == 16'h0000) ? int'(DEFAULT_DIV) : int'(baud_div));

    initial begin
        line_out = 1'b1;
        rts_n    = 1'b0;
    end

    task automatic set_rts(input logic v);
        rts_n = v;
    endtask

    // one character, lsb first, optional parity bit before the stop bit
    task automatic send_char(input logic [7:0] b, input logic par_en, input logic par_bit, input logic stop_bit);
        logic [10:0] frame;
        int          n;
        frame = par_en ? {stop_bit, par_bit, b, 1'b0} : {1'b1, stop_bit, b, 1'b0};
        n = par_en ? 11 : 10;
        wait (bus_de == 1'b0);
        for (int i = 0; i < n; i++) begin
            line_out = frame[i];
            repeat (bit_cyc) @(posedge clk_sys);
            #1;
        end
        line_out = 1'b1;
    endtask

    // decodes what the unit sends, sampled mid-bit; ninth bit is parity or stop
    always begin
        @(negedge line_in);
        repeat (bit_cyc / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge clk_sys);
            rx_byte[i] = line_in;
        end
        repeat (bit_cyc) @(posedge clk_sys);
        rx_ninth = line_in;
        rx_q.push_back(rx_byte);
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
`default_nettype none
module testbench
    import serial_host_flow_bridge_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH at %0t got %h exp %h", $time, (got), (exp)); end end

    logic        clk_sys, nrst, rs485_mode, rts_enable, parity_enable, parity_odd;
    logic [15:0] baud_div;
    logic        host_txd, host_cts_n, bus_txd, bus_de, peer_line, peer_rts_n, bus_wire, peer_in;
    logic [7:0]  radio_out_data, radio_in_data;
    logic        radio_out_valid, radio_out_ready, radio_in_valid, radio_in_ready;
    logic        parity_err, frame_err, overrun_err;
    logic [7:0]  out_q[$];
    int          miscompares = 0;
    int          checks = 0;
    int          perr_cnt = 0;
    int          ferr_cnt = 0;
    int          oerr_cnt = 0;

    // released bus idles high; the peer only listens to what the unit drives
    assign bus_wire = bus_de ? bus_txd : peer_line;
    assign peer_in  = rs485_mode ? (bus_de ? bus_txd : 1'b1) : host_txd;

    serial_host_flow_bridge u_serial_host_flow_bridge (
        .clk_sys(clk_sys), .nrst(nrst), .rs485_mode(rs485_mode), .rts_enable(rts_enable),
        .parity_enable(parity_enable), .parity_odd(parity_odd), .baud_div(baud_div),
        .host_rxd(peer_line), .host_txd(host_txd), .host_rts_n(peer_rts_n), .host_cts_n(host_cts_n),
        .bus_rxd(bus_wire), .bus_txd(bus_txd), .bus_de(bus_de),
        .radio_out_data(radio_out_data), .radio_out_valid(radio_out_valid), .radio_out_ready(radio_out_ready),
        .radio_in_data(radio_in_data), .radio_in_valid(radio_in_valid), .radio_in_ready(radio_in_ready),
        .parity_err(parity_err), .frame_err(frame_err), .overrun_err(overrun_err)
    );

    serial_peer_model u_serial_peer_model (
        .clk_sys(clk_sys), .baud_div(baud_div), .line_in(peer_in), .bus_de(bus_de),
        .line_out(peer_line), .rts_n(peer_rts_n)
    );

    initial clk_sys = 1'b0;
    always #2.5 clk_sys = ~clk_sys;

    // collects radio-side bytes and error pulses
    always @(posedge clk_sys) begin
        if (radio_out_valid === 1'b1 && radio_out_ready === 1'b1) out_q.push_back(radio_out_data);
        if (parity_err === 1'b1) perr_cnt++;
        if (frame_err === 1'b1) ferr_cnt++;
        if (overrun_err === 1'b1) oerr_cnt++;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic results();
        if (miscompares == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic expect_out(input logic [7:0] b);
        logic [7:0] got;
        got = 8'hXX;
        for (int k = 0; k < 40000 && out_q.size() == 0; k++) tick(1);
        if (out_q.size() > 0) got = out_q.pop_front();
        `CHECK(got, b)
    endtask

    task automatic expect_rx(input logic [7:0] b);
        logic [7:0] got;
        got = 8'hXX;
        for (int k = 0; k < 40000 && u_serial_peer_model.rx_q.size() == 0; k++) tick(1);
        if (u_serial_peer_model.rx_q.size() > 0) got = u_serial_peer_model.rx_q.pop_front();
        `CHECK(got, b)
    endtask

    task automatic radio_send(input logic [7:0] b);
        int k;
        k = 0;
        radio_in_data = b;
        radio_in_valid = 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (radio_in_ready !== 1'b1 && k < 40000);
        #1;
        radio_in_valid = 1'b0;
        `CHECK(k < 40000, 1'b1)
    endtask

    task automatic scen_reset();
        `CHECK({host_txd, bus_txd, bus_de}, 3'h6)
        `CHECK(host_cts_n, 1'b0)
        `CHECK(radio_out_valid, 1'b0)
    endtask

    task automatic scen_parity();
        logic [7:0] b;
        b = 8'h5B;
        parity_enable = 1'b1;
        for (int odd = 0; odd < 2; odd++) begin
            parity_odd = odd[0];
            tick(2);
            u_serial_peer_model.send_char(b, 1'b1, ^b ^ odd[0], 1'b1);
            expect_out(b);
            u_serial_peer_model.send_char(b, 1'b1, ~(^b ^ odd[0]), 1'b1);
            tick(40);
            `CHECK(perr_cnt, odd + 1)
            radio_send(b);
            expect_rx(b);
            `CHECK(u_serial_peer_model.rx_ninth, ^b ^ odd[0])
        end
        parity_enable = 1'b0;
        parity_odd = 1'b0;
        u_serial_peer_model.send_char(8'h81, 1'b0, 1'b0, 1'b0);
        tick(40);
        `CHECK(ferr_cnt, 1)
        `CHECK(out_q.size(), 0)
    endtask

    task automatic scen_bus();
        rs485_mode = 1'b1;
        tick(3);
        `CHECK(host_cts_n, 1'b1)
        u_serial_peer_model.send_char(8'hFE, 1'b0, 1'b0, 1'b1);
        u_serial_peer_model.send_char(8'h01, 1'b0, 1'b0, 1'b1);
        expect_out(8'hFE);
        expect_out(8'h01);
        radio_send(8'hC5);
        tick(1);
        `CHECK({bus_de, bus_txd}, 2'h2)
        expect_rx(8'hC5);
        tick(80);
        `CHECK(bus_de, 1'b0)
        `CHECK(host_txd, 1'b1)
        rs485_mode = 1'b0;
        tick(3);
    endtask

    task automatic scen_rts();
        int bad;
        bad = 0;
        rts_enable = 1'b1;
        u_serial_peer_model.set_rts(1'b1);
        tick(4);
        radio_in_data = 8'h3A;
        radio_in_valid = 1'b1;
        for (int i = 0; i < 200; i++) begin
            tick(1);
            if (host_txd !== 1'b1 || radio_in_ready !== 1'b0) bad++;
        end
        `CHECK(bad, 0)
        `CHECK(host_cts_n, 1'b0)
        u_serial_peer_model.set_rts(1'b0);
        radio_send(8'h3A);
        expect_rx(8'h3A);
        tick(80);
        rts_enable = 1'b0;
        u_serial_peer_model.set_rts(1'b1);
        radio_send(8'h4B);
        expect_rx(8'h4B);
        u_serial_peer_model.set_rts(1'b0);
        tick(80);
    endtask

    task automatic scen_fifo();
        radio_out_ready = 1'b0;
        for (int i = 0; i < 17; i++) begin
            `CHECK(host_cts_n, logic'(i > 12))
            u_serial_peer_model.send_char(8'hA0 + 8'(i), 1'b0, 1'b0, 1'b1);
            tick(40);
        end
        `CHECK(oerr_cnt, 1)
        `CHECK(radio_in_ready, 1'b1)
        radio_out_ready = 1'b1;
        for (int i = 0; i < 16; i++) expect_out(8'hA0 + 8'(i));
        tick(4);
        `CHECK(host_cts_n, 1'b0)
    endtask

    task automatic scen_rate();
        baud_div = 16'h0000;
        tick(2);
        u_serial_peer_model.send_char(8'h96, 1'b0, 1'b0, 1'b1);
        expect_out(8'h96);
    endtask

    initial begin
        nrst = 1'b0;
        {rs485_mode, rts_enable, parity_enable, parity_odd} = 4'h0;
        baud_div = 16'h0002;
        radio_out_ready = 1'b1;
        radio_in_data = 8'h00;
        radio_in_valid = 1'b0;
        tick(2);
        scen_reset();
        nrst = 1'b1;
        tick(2);
        scen_parity();
        scen_bus();
        scen_rts();
        scen_fifo();
        scen_rate();
        results();
    end

    // cuts a hang short
    initial begin
        #400_000;
        miscompares++;
        results();
    end
endmodule
`default_nettype wire
